/* File: hw/otp_top.sv */
// Termination mode transition tracker around power-down entry and exit
`include "otp_cfg.svh"

// Behaviour
// - Windows only while DLL frozen in power-down
// - Entry lead interval is write latency minus one
// - Entry window spans lead to command-delay end
// - Running refresh extends entry window to later end
// - Lead start excluded, window end cycle included
// - Turn-on within min and max of both paths
// - Turn-off within min and max of both paths
// - Exit window: lead before high, relock after
// - Exit lead interval is write latency minus one
// - Overlap: entry start through exit end
// - Overlap: exit start through entry end
// - Changes before lead use synchronous timing
// - Asynchronous path ignores additive latency
module otp_top (
  // Clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  // Controller pins
  input  wire logic             CKE,
  input  wire logic             TERMINATION_CONTROL_INPUT,
  // Command decode and mode register zero
  input  wire logic             REFRESH_CMD,
  input  wire logic             DLL_FREEZE_SELECT_BIT,
  input  wire otp_pkg::otp_wl_t WRITE_LATENCY,
  // Termination state
  output logic                  TERM_ON,
  output logic                  TERM_ASYNC,
  output logic                  PD_ACTIVE,
  // Window flags, aligned with the synchronous response
  output logic                  ENTRY_WINDOW,
  output logic                  EXIT_WINDOW,
  output logic                  TRANSITION_WINDOW
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic otp_pkg::otp_wl_t otp_sync_depth(
    input otp_pkg::otp_wl_t wl
  );
    otp_pkg::otp_wl_t d;
    d = wl - otp_pkg::otp_wl_t'(`OTP_SYNC_OFS);
    if (wl <= otp_pkg::otp_wl_t'(`OTP_SYNC_OFS + 1)) begin
      d = otp_pkg::otp_wl_t'(1);
    end else if (d > otp_pkg::otp_wl_t'(`OTP_HIST_DEPTH)) begin
      d = otp_pkg::otp_wl_t'(`OTP_HIST_DEPTH);
    end
    return d;
  endfunction

  function automatic otp_pkg::otp_cnt_t otp_max_cnt(
    input otp_pkg::otp_cnt_t a,
    input otp_pkg::otp_cnt_t b
  );
    return (a > b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] pins;
  logic [1:0] lvls;
  logic       cke_s;
  logic       odt_s;

  assign pins = {TERMINATION_CONTROL_INPUT, CKE};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    otp_sync3 u_sync (
      .clk (REF_CLK),
      .rst (RST),
      .pin (pins[g]),
      .lvl (lvls[g])
    );
  end

  assign cke_s = lvls[0];
  assign odt_s = lvls[1];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and window history

  otp_pkg::otp_top_t st_q;
  otp_pkg::otp_top_t st_d;
  otp_pkg::otp_ent_t hist_in;
  otp_pkg::otp_ent_t hist_out;
  otp_pkg::otp_wl_t  depth;
  otp_pkg::otp_age_t on_max;
  otp_pkg::otp_age_t off_max;
  logic              frozen;
  logic              fall;
  logic              rise;

  assign frozen = ~DLL_FREEZE_SELECT_BIT;
  assign fall   = frozen & st_q.cke_prev & ~cke_s;
  assign rise   = frozen & ~st_q.cke_prev & cke_s;

  // Tap depth equals synchronous latency; lead start is one beyond it
  assign depth = otp_sync_depth(WRITE_LATENCY);

  always_comb begin
    hist_in.odt    = odt_s;
    hist_in.entry  = fall | (st_q.entry_rem != '0);
    hist_in.exit_w = rise | (st_q.exit_rem != '0);
  end

  otp_hist u_hist (
    .clk        (REF_CLK),
    .rst        (RST),
    .din        (hist_in),
    .mark_entry (fall),
    .mark_exit  (rise),
    .tap        (depth),
    .dout       (hist_out)
  );

  // Latest legal response of either path, in cycles after the edge
  assign on_max = otp_pkg::otp_age_t'(otp_max_cnt(
    otp_pkg::otp_cnt_t'(`OTP_ASYNC_MAX_CYC),
    otp_pkg::otp_cnt_t'(depth) +
    otp_pkg::otp_cnt_t'(1 + `OTP_SKEW_MAX_CYC)));
  assign off_max = on_max;

  ////////////////////////////////////////////////////////////////////////////
  // State update

  always_comb begin
    st_d          = st_q;
    st_d.cke_prev = cke_s;
    st_d.odt_prev = odt_s;

    // Refresh in progress, counted to its end
    if (REFRESH_CMD) begin
      st_d.ref_rem = otp_pkg::otp_cnt_t'(`OTP_RFC_CYC - 1);
    end else if (st_q.ref_rem != '0) begin
      st_d.ref_rem = st_q.ref_rem - 1'b1;
    end

    // Entry window tail: later of command delay and refresh end
    if (fall) begin
      st_d.entry_rem = otp_max_cnt(st_q.ref_rem,
        otp_pkg::otp_cnt_t'(`OTP_CPDED_CYC));
    end else if (st_q.entry_rem != '0) begin
      st_d.entry_rem = st_q.entry_rem - 1'b1;
    end

    // Exit window tail: relock time after first high
    if (rise) begin
      st_d.exit_rem = otp_pkg::otp_cnt_t'(`OTP_XPDLL_CYC);
    end else if (st_q.exit_rem != '0) begin
      st_d.exit_rem = st_q.exit_rem - 1'b1;
    end

    // Response mode
    case (st_q.mode)
      otp_pkg::OTP_SYNC: begin
        if (frozen && !cke_s) begin
          st_d.mode = otp_pkg::OTP_ASYNC;
        end
      end
      otp_pkg::OTP_ASYNC: begin
        if (!frozen) begin
          st_d.mode = otp_pkg::OTP_SYNC;
        end else if (cke_s) begin
          st_d.mode = otp_pkg::OTP_RETURN;
        end
      end
      otp_pkg::OTP_RETURN: begin
        // Hand back after relock once the pipeline matches, so no glitch, or at once when the DLL is not frozen
        if (frozen && !cke_s) begin
          st_d.mode = otp_pkg::OTP_ASYNC;
        end else if (!frozen ||
                     (st_q.exit_rem == '0 && hist_out.odt == odt_s)) begin
          st_d.mode = otp_pkg::OTP_SYNC;
        end
      end
      default: begin
        st_d.mode = otp_pkg::OTP_SYNC;
      end
    endcase

    // Synchronous path from the delay line, asynchronous from the pin
    if (st_d.mode == otp_pkg::OTP_SYNC) begin
      st_d.term = hist_out.odt;
    end else begin
      st_d.term = odt_s;
    end

    st_d.async_o   = (st_d.mode != otp_pkg::OTP_SYNC);
    st_d.pd        = ~cke_s;
    st_d.entry_win = hist_out.entry;
    st_d.exit_win  = hist_out.exit_w;
    // Union keeps overlapping windows as one span
    st_d.trans_win = hist_out.entry | hist_out.exit_w;

    // Cycles since the last edge of each direction
    if (odt_s && !st_q.odt_prev) begin
      st_d.age_on = otp_pkg::otp_age_t'(1);
    end else if (st_q.age_on != '1) begin
      st_d.age_on = st_q.age_on + 1'b1;
    end
    if (!odt_s && st_q.odt_prev) begin
      st_d.age_off = otp_pkg::otp_age_t'(1);
    end else if (st_q.age_off != '1) begin
      st_d.age_off = st_q.age_off + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign TERM_ON           = st_q.term;
  assign TERM_ASYNC        = st_q.async_o;
  assign PD_ACTIVE         = st_q.pd;
  assign ENTRY_WINDOW      = st_q.entry_win;
  assign EXIT_WINDOW       = st_q.exit_win;
  assign TRANSITION_WINDOW = st_q.trans_win;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  property p_no_win_unfrozen;
    (!frozen && st_q.entry_rem == '0 && st_q.exit_rem == '0)
      |=> (st_q.entry_rem == '0 && st_q.exit_rem == '0);
  endproperty
  a_no_win_unfrozen: assert property (p_no_win_unfrozen)
    else $error("window opened with DLL not frozen");

  property p_entry_open;
    fall |=> ENTRY_WINDOW && TRANSITION_WINDOW;
  endproperty
  a_entry_open: assert property (p_entry_open)
    else $error("entry window not open after clock enable fell");

  property p_entry_refresh;
    (fall && st_q.ref_rem > otp_pkg::otp_cnt_t'(`OTP_CPDED_CYC))
      |=> st_q.entry_rem == $past(st_q.ref_rem);
  endproperty
  a_entry_refresh: assert property (p_entry_refresh)
    else $error("entry window not held to refresh end");

  property p_entry_min;
    (fall && st_q.ref_rem <= otp_pkg::otp_cnt_t'(`OTP_CPDED_CYC))
      |=> st_q.entry_rem == otp_pkg::otp_cnt_t'(`OTP_CPDED_CYC)
      ##1 st_q.entry_rem == otp_pkg::otp_cnt_t'(`OTP_CPDED_CYC - 1);
  endproperty
  a_entry_min: assert property (p_entry_min)
    else $error("entry window tail length wrong");

  property p_exit_open;
    rise |=> EXIT_WINDOW
      && st_q.exit_rem == otp_pkg::otp_cnt_t'(`OTP_XPDLL_CYC);
  endproperty
  a_exit_open: assert property (p_exit_open)
    else $error("exit window not opened on clock enable rise");

  property p_overlap;
    ($fell(ENTRY_WINDOW) && EXIT_WINDOW) or
    ($fell(EXIT_WINDOW) && ENTRY_WINDOW) |-> TRANSITION_WINDOW;
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("overlapping windows not merged");

  property p_on_bound;
    ($rose(TERM_ON) && frozen) |->
      st_q.age_on >= otp_pkg::otp_age_t'(`OTP_ASYNC_MIN_CYC)
      && st_q.age_on <= on_max;
  endproperty
  a_on_bound: assert property (p_on_bound)
    else $error("termination turned on outside allowed range");

  property p_off_bound;
    ($fell(TERM_ON) && frozen) |->
      st_q.age_off >= otp_pkg::otp_age_t'(`OTP_ASYNC_MIN_CYC)
      && st_q.age_off <= off_max;
  endproperty
  a_off_bound: assert property (p_off_bound)
    else $error("termination turned off outside allowed range");

  property p_async_follow;
    (st_q.mode == otp_pkg::OTP_ASYNC && frozen && !cke_s)
      |=> TERM_ON == $past(odt_s) && TERM_ASYNC;
  endproperty
  a_async_follow: assert property (p_async_follow)
    else $error("asynchronous path did not follow the input");

endmodule

/* File: hw/otp_cfg.svh */
// Timing, sizing and offset constants for the termination transition block
`ifndef OTP_CFG_SVH
`define OTP_CFG_SVH

// Reference clock period, 40 MHz
`define OTP_TCK_PS        25000

// Field widths and history depth
`define OTP_WL_W          4
`define OTP_CNT_W         8
`define OTP_AGE_W         5
`define OTP_HIST_DEPTH    13

// Latency offsets applied to write latency
`define OTP_LEAD_OFS      1
`define OTP_SYNC_OFS      2

// Interval figures in their own units
`define OTP_CPDED_NCK     1
`define OTP_RFC_PS        160000
`define OTP_XPDLL_PS      24000
`define OTP_ASYNC_MIN_PS  2000
`define OTP_ASYNC_MAX_PS  8500
`define OTP_SKEW_MIN_PS   0
`define OTP_SKEW_MAX_PS   400

// Conversion to cycles: least times round up, longest times round down
`define OTP_CEIL_CYC(t)   (((t) + `OTP_TCK_PS - 1) / `OTP_TCK_PS)
`define OTP_FLOOR_CYC(t)  ((t) / `OTP_TCK_PS)
`define OTP_AT_LEAST1(c)  (((c) < 1) ? 1 : (c))

`define OTP_CPDED_CYC     `OTP_AT_LEAST1(`OTP_CPDED_NCK)
`define OTP_RFC_CYC       `OTP_AT_LEAST1(`OTP_CEIL_CYC(`OTP_RFC_PS))
`define OTP_XPDLL_CYC     `OTP_AT_LEAST1(`OTP_CEIL_CYC(`OTP_XPDLL_PS))
`define OTP_ASYNC_MIN_CYC `OTP_AT_LEAST1(`OTP_CEIL_CYC(`OTP_ASYNC_MIN_PS))
`define OTP_ASYNC_MAX_CYC `OTP_AT_LEAST1(`OTP_FLOOR_CYC(`OTP_ASYNC_MAX_PS))
`define OTP_SKEW_MAX_CYC  `OTP_FLOOR_CYC(`OTP_SKEW_MAX_PS)

`endif

/* File: hw/otp_pkg.sv */
// Shared types for the termination transition block
`include "otp_cfg.svh"

package otp_pkg;

  typedef logic [`OTP_WL_W-1:0]  otp_wl_t;
  typedef logic [`OTP_CNT_W-1:0] otp_cnt_t;
  typedef logic [`OTP_AGE_W-1:0] otp_age_t;

  // Termination response mode, Gray coded along SYNC, ASYNC, RETURN
  typedef enum logic [1:0] {
    OTP_SYNC   = 2'h0,
    OTP_ASYNC  = 2'h1,
    OTP_RETURN = 2'h3
  } otp_mode_t;

  // One history entry: sampled termination input and its window tags
  typedef struct packed {
    logic odt;
    logic entry;
    logic exit_w;
  } otp_ent_t;

  typedef otp_ent_t [`OTP_HIST_DEPTH-1:0] otp_line_t;

  typedef struct packed {
    otp_line_t line;
  } otp_hist_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } otp_sync_t;

  typedef struct packed {
    logic      cke_prev;
    logic      odt_prev;
    otp_mode_t mode;
    otp_cnt_t  ref_rem;
    otp_cnt_t  entry_rem;
    otp_cnt_t  exit_rem;
    otp_age_t  age_on;
    otp_age_t  age_off;
    logic      term;
    logic      async_o;
    logic      pd;
    logic      entry_win;
    logic      exit_win;
    logic      trans_win;
  } otp_top_t;

endpackage

/* File: hw/otp_sync3.sv */
// Three-stage pin synchroniser that accepts a level once stages agree
module otp_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw pin and accepted level
  input  wire logic pin,
  output logic      lvl
);

  otp_pkg::otp_sync_t st_q;
  otp_pkg::otp_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // First stage is read only by the second
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lvl = st_q.lvl;

endmodule

/* File: hw/otp_hist.sv */
// Delay line of termination samples with retroactive window tagging
`include "otp_cfg.svh"

module otp_hist (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // New sample and tag-all strobes
  input  wire otp_pkg::otp_ent_t din,
  input  wire logic              mark_entry,
  input  wire logic              mark_exit,
  // Tap selection, 1 to depth
  input  wire otp_pkg::otp_wl_t  tap,
  output otp_pkg::otp_ent_t      dout
);

  otp_pkg::otp_hist_t st_q;
  otp_pkg::otp_hist_t st_d;

  always_comb begin
    st_d = st_q;
    for (int i = `OTP_HIST_DEPTH - 1; i > 0; i--) begin
      st_d.line[i] = st_q.line[i-1];
    end
    st_d.line[0] = din;
    // Samples already in flight fall inside the window just opened
    for (int i = 0; i < `OTP_HIST_DEPTH; i++) begin
      if (mark_entry) begin
        st_d.line[i].entry = 1'b1;
      end
      if (mark_exit) begin
        st_d.line[i].exit_w = 1'b1;
      end
    end
  end

  always_comb begin
    dout        = st_q.line[tap - 1'b1];
    dout.entry  = dout.entry | mark_entry;
    dout.exit_w = dout.exit_w | mark_exit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

/* File: test/otp_ctrl_model.sv */
// Memory controller model driving the termination block's pins
module otp_ctrl_model (
  // Clock
  input  wire logic clk,
  // Controller pins
  output logic      cke,
  output logic      odt,
  output logic      refresh_cmd,
  output logic      dll_frz
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cke = 1'h1;
    odt = 1'h0;
    refresh_cmd = 1'h0;
    dll_frz = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Only refresh is issued, and only while not in power-down;
  // pd drops clock enable right behind the refresh command
  task automatic refresh(input logic pd);
    @(negedge clk);
    if (cke === 1'h1) begin
      refresh_cmd = 1'h1;
      @(negedge clk);
      refresh_cmd = 1'h0;
      if (pd) begin
        cke = 1'h0;
      end
    end
  endtask

  // Termination level driven without relying on its response time
  task automatic set_odt(input logic v);
    @(negedge clk);
    odt = v;
  endtask

  task automatic set_cke(input logic v);
    @(negedge clk);
    cke = v;
  endtask

  task automatic set_dll(input logic v);
    @(negedge clk);
    dll_frz = v;
  endtask
endmodule

/* File: test/test_odt_pd_mode_transition.sv */
// Self-checking bench for the termination transition tracker
`include "otp_cfg.svh"

module test_odt_pd_mode_transition;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WL        = 6;
  localparam int D         = WL - 2;
  localparam int SYNC_LAT  = 3 + D + 1;
  localparam int ASYNC_LAT = 3 + `OTP_ASYNC_MIN_CYC;
  localparam int WL2       = 8;
  localparam int D2        = WL2 - 2;

  logic ref_clk, rst, cke, odt, refresh_cmd, dll_frz;
  otp_pkg::otp_wl_t wl;
  logic term_on, term_async, pd_active, entry_w, exit_w, trans_w;
  int   num_errors = 0;
  int   n_tests    = 0;

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  otp_ctrl_model i_otp_ctrl_model (
    .clk         (ref_clk),
    .cke         (cke),
    .odt         (odt),
    .refresh_cmd (refresh_cmd),
    .dll_frz     (dll_frz)
  );

  otp_top i_otp_top (
    .REF_CLK                   (ref_clk),
    .RST                       (rst),
    .CKE                       (cke),
    .TERMINATION_CONTROL_INPUT (odt),
    .REFRESH_CMD               (refresh_cmd),
    .DLL_FREEZE_SELECT_BIT     (dll_frz),
    .WRITE_LATENCY             (wl),
    .TERM_ON                   (term_on),
    .TERM_ASYNC                (term_async),
    .PD_ACTIVE                 (pd_active),
    .ENTRY_WINDOW              (entry_w),
    .EXIT_WINDOW               (exit_w),
    .TRANSITION_WINDOW         (trans_w)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: sig = term_on;
      1: sig = entry_w;
      2: sig = exit_w;
      3: sig = trans_w;
      default: sig = term_async;
    endcase
  endfunction

  // Edges until output s shows v, the next edge counted as zero
  task automatic wait_for(input int s, input logic v, output int n);
    n = 0;
    @(posedge ref_clk);
    #1;
    while (sig(s) !== v) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 60) begin
        num_errors++;
        $display("ERROR output %0d expected %0d seen %0d", s, v, sig(s));
        final_report();
      end
    end
  endtask

  task automatic run_len(input int s, output int n);
    int w;
    wait_for(s, 1'h1, w);
    n = 0;
    while (sig(s) === 1'h1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      num_errors++;
      $display("ERROR run of output %0d expected end seen %0d", s, n);
      final_report();
    end
  endtask

  task automatic odt_pulse(input string name, input int lat);
    int n;
    i_otp_ctrl_model.set_odt(1'h1);
    wait_for(0, 1'h1, n);
    check({name, " on"}, 8'(lat), 8'(n));
    repeat (2) @(negedge ref_clk);
    i_otp_ctrl_model.set_odt(1'h0);
    wait_for(0, 1'h0, n);
    check({name, " off"}, 8'(lat), 8'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic sc_entry_exit();
    int n;
    i_otp_ctrl_model.set_cke(1'h0);
    run_len(1, n);
    check("entry len", 8'(D + 1 + `OTP_CPDED_CYC), 8'(n));
    check("pd async", 8'h03, {6'h00, term_async, pd_active});
    odt_pulse("pd", ASYNC_LAT);
    i_otp_ctrl_model.set_cke(1'h1);
    run_len(2, n);
    check("exit len", 8'(D + 1 + `OTP_XPDLL_CYC), 8'(n));
    wait_for(4, 1'h0, n);
    odt_pulse("after exit", SYNC_LAT);
  endtask

  task automatic sc_refresh();
    int n;
    i_otp_ctrl_model.refresh(1'h1);
    run_len(1, n);
    check("refresh len", 8'h01, 8'(n > D + 1 + `OTP_CPDED_CYC
          && n <= D + 1 + `OTP_RFC_CYC));
    i_otp_ctrl_model.set_cke(1'h1);
    repeat (40) @(negedge ref_clk);
  endtask

  task automatic sc_overlap();
    int   rises;
    logic prev;
    rises = 0;
    prev = 1'h0;
    fork
      begin
        i_otp_ctrl_model.set_cke(1'h0);
        repeat (3) @(posedge ref_clk);
        i_otp_ctrl_model.set_cke(1'h1);
        repeat (3) @(posedge ref_clk);
        i_otp_ctrl_model.set_cke(1'h0);
        repeat (3) @(posedge ref_clk);
        i_otp_ctrl_model.set_cke(1'h1);
      end
      repeat (60) begin
        @(posedge ref_clk);
        #1;
        if (trans_w === 1'h1 && prev !== 1'h1) rises++;
        prev = trans_w;
      end
    join
    check("overlap runs", 8'h01, 8'(rises));
  endtask

  task automatic sc_dll_on();
    int hits;
    hits = 0;
    i_otp_ctrl_model.set_dll(1'h1);
    i_otp_ctrl_model.set_cke(1'h0);
    repeat (30) begin
      @(posedge ref_clk);
      #1;
      if (trans_w !== 1'h0 || term_async !== 1'h0) hits++;
    end
    check("dll on windows", 8'h00, 8'(hits));
    check("dll on pd", 8'h01, {7'h00, pd_active});
    odt_pulse("dll on", SYNC_LAT);
    i_otp_ctrl_model.set_cke(1'h1);
    repeat (10) @(negedge ref_clk);
    i_otp_ctrl_model.set_dll(1'h0);
  endtask

  // Longer write latency moves both the sync path and the entry tags
  task automatic sc_wl();
    int n;
    @(negedge ref_clk);
    wl = otp_pkg::otp_wl_t'(WL2);
    repeat (20) @(negedge ref_clk);
    odt_pulse("wl long", 3 + D2 + 1);
    i_otp_ctrl_model.set_cke(1'h0);
    run_len(1, n);
    check("wl entry len", 8'(D2 + 1 + `OTP_CPDED_CYC), 8'(n));
    i_otp_ctrl_model.set_cke(1'h1);
    run_len(2, n);
    check("wl exit len", 8'(D2 + 1 + `OTP_XPDLL_CYC), 8'(n));
    wait_for(4, 1'h0, n);
    @(negedge ref_clk);
    wl = otp_pkg::otp_wl_t'(WL);
    repeat (20) @(negedge ref_clk);
  endtask

  // Reset in mid-run clears every output and the block recovers
  task automatic sc_mid_reset();
    @(negedge ref_clk);
    rst = 1'h1;
    repeat (2) @(negedge ref_clk);
    check("mid reset outputs", 8'h00, {2'h0, term_on, term_async,
          pd_active, entry_w, exit_w, trans_w});
    rst = 1'h0;
    repeat (40) @(negedge ref_clk);
    odt_pulse("after reset", SYNC_LAT);
  endtask

  initial begin
    wl = otp_pkg::otp_wl_t'(WL);
    rst = 1'h1;
    repeat (10) @(negedge ref_clk);
    check("reset outputs", 8'h00, {2'h0, term_on, term_async, pd_active,
          entry_w, exit_w, trans_w});
    repeat (2) @(negedge ref_clk);
    rst = 1'h0;
    repeat (40) @(negedge ref_clk);
    odt_pulse("idle", SYNC_LAT);
    sc_entry_exit();
    repeat (10) @(negedge ref_clk);
    sc_refresh();
    sc_overlap();
    repeat (40) @(negedge ref_clk);
    sc_dll_on();
    repeat (20) @(negedge ref_clk);
    sc_wl();
    sc_mid_reset();
    final_report();
  end
endmodule
